/* core/gpio_port_regs.vh */
// register offsets, reset values and unlock key of one gpio port
`ifndef GPIO_PORT_REGS_VH
`define GPIO_PORT_REGS_VH
// byte offsets, 12-bit address window
`define OFF_DATA_LAST 12'h3fc
`define OFF_DIR 12'h400
`define OFF_IS 12'h404
`define OFF_IBE 12'h408
`define OFF_IEV 12'h40c
`define OFF_IM 12'h410
`define OFF_RIS 12'h414
`define OFF_MIS 12'h418
`define OFF_ICR 12'h41c
`define OFF_AFSEL 12'h420
`define OFF_DR2 12'h500
`define OFF_DR4 12'h504
`define OFF_DR8 12'h508
`define OFF_ODR 12'h50c
`define OFF_PUR 12'h510
`define OFF_PDR 12'h514
`define OFF_SLR 12'h518
`define OFF_DEN 12'h51c
`define OFF_LOCK 12'h520
`define OFF_CR 12'h524
`define OFF_PID_BASE 12'hfd0
`define OFF_CID_BASE 12'hff0
// data mask field of the address
`define MASK_LSB 2
`define MASK_MSB 9
// reset values
`define RST_ZERO 8'h00
`define RST_DR2 8'hff
`define RST_CR_PLAIN 8'hff
// unlock key and lock status
`define UNLOCK_KEY 32'h1acce551
`define LOCKED_VAL 32'h00000001
`endif

/* core/irq_detect.v */
// per-pin interrupt detector: edge/level select and sticky edge status
`timescale 1ns/1ns
module irq_detect
(
  // clock and reset
  input wire clk,
  input wire rst_n,
  // synchronised pin level and its previous sample
  input wire level,
  input wire level_prev,
  // configuration
  input wire sense,
  input wire both,
  input wire polarity,
  // clear strobe
  input wire clear,
  // raw status
  output wire raw
);
  reg edge_flag;
  wire rise;
  wire fall;
  wire edge_hit;
  wire level_hit;

  assign rise = level & ~level_prev;
  assign fall = ~level & level_prev;
  // sense 0 is edge; both overrides polarity
  assign edge_hit = both ? (rise | fall) : (polarity ? rise : fall);
  assign level_hit = (level == polarity);

  // set wins over a same-cycle clear
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      edge_flag <= 1'b0;
    else if (!sense && edge_hit)
      edge_flag <= 1'b1;
    else if (clear)
      edge_flag <= 1'b0;
  end

  assign raw = sense ? level_hit : edge_flag;
endmodule // irq_detect

/* core/gpio_port.v */
// one general-purpose i/o port with masked data access and pin interrupts
`timescale 1ns/1ns
`include "gpio_port_regs.vh"
module gpio_port
#(
  // which pins carry debug roles and need commit protection
  parameter [7:0] DEBUG_PINS = 8'h00,
  // which bits have a pad
  parameter [7:0] CONNECTED = 8'hff,
  // identification bytes, values arbitrary
  parameter [63:0] PERIPH_ID = 64'h0000000000000000,
  parameter [31:0] CELL_ID = 32'h00000000
)
(
  // clock and reset
  input wire clk,
  input wire rst_n,
  // register port
  input wire [11:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata,
  // pins
  input wire [7:0] pin_in,
  output reg [7:0] pin_out,
  output reg [7:0] pin_oe_n,
  // alternate peripheral
  input wire [7:0] periph_out,
  input wire [7:0] periph_oe,
  output reg [7:0] periph_in,
  // pad control
  output reg [7:0] alt_function_select,
  output reg [7:0] digital_enable_select,
  output reg [7:0] pull_up_select,
  output reg [7:0] pull_down_select,
  output reg [7:0] drive_2ma_select,
  output reg [7:0] drive_4ma_select,
  output reg [7:0] drive_8ma_select,
  output reg [7:0] open_drain_select,
  output reg [7:0] slew_select,
  // interrupt to controller
  output reg port_irq
);
  // ==========================================================
  // state
  reg [7:0] pin_value_reg;
  reg [7:0] pin_direction_select;
  reg [7:0] irq_sense_select;
  reg [7:0] irq_both_edge_select;
  reg [7:0] irq_polarity_select;
  reg [7:0] irq_enable_mask;
  reg [7:0] commit_enable_reg;
  reg unlocked;
  reg [7:0] sync1;
  reg [7:0] sync2;
  reg [7:0] sync3;
  wire [7:0] irq_raw_status;
  wire [7:0] irq_masked_status;
  wire [7:0] mask;
  wire [7:0] wbyte;
  wire data_hit;
  wire [7:0] clear_bits;
  reg [31:0] next_rdata;
  reg [7:0] next_out;
  reg [7:0] next_oe_n;

  assign data_hit = (addr <= `OFF_DATA_LAST);
  assign mask = addr[`MASK_MSB:`MASK_LSB];
  assign wbyte = wdata[7:0] & CONNECTED;
  assign clear_bits = (wr && addr == `OFF_ICR) ? wbyte : 8'h00;

  // ==========================================================
  // input synchroniser
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1 <= 8'h00;
      sync2 <= 8'h00;
      sync3 <= 8'h00;
    end
    else
    begin
      sync1 <= pin_in;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // ==========================================================
  // interrupt detectors
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1)
    begin : g_irq
      irq_detect u_det
      (
        .clk(clk),
        .rst_n(rst_n),
        .level(sync2[i]),
        .level_prev(sync3[i]),
        .sense(irq_sense_select[i]),
        .both(irq_both_edge_select[i]),
        .polarity(irq_polarity_select[i]),
        .clear(clear_bits[i]),
        .raw(irq_raw_status[i])
      );
    end
  endgenerate

  assign irq_masked_status = irq_raw_status & irq_enable_mask;

  // ==========================================================
  // register writes
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_value_reg <= `RST_ZERO;
      pin_direction_select <= `RST_ZERO;
      irq_sense_select <= `RST_ZERO;
      irq_both_edge_select <= `RST_ZERO;
      irq_polarity_select <= `RST_ZERO;
      irq_enable_mask <= `RST_ZERO;
      alt_function_select <= DEBUG_PINS;
      digital_enable_select <= DEBUG_PINS;
      pull_up_select <= DEBUG_PINS;
      pull_down_select <= `RST_ZERO;
      drive_2ma_select <= `RST_DR2;
      drive_4ma_select <= `RST_ZERO;
      drive_8ma_select <= `RST_ZERO;
      open_drain_select <= `RST_ZERO;
      slew_select <= `RST_ZERO;
      commit_enable_reg <= `RST_CR_PLAIN & ~DEBUG_PINS;
      unlocked <= 1'b0;
    end
    else
    begin
      // input pins capture the synchronised level
      pin_value_reg <= (pin_value_reg & pin_direction_select)
                       | (sync2 & ~pin_direction_select & CONNECTED);
      if (wr && data_hit)
        pin_value_reg <= (pin_value_reg & ~(mask & pin_direction_select))
                         | (wbyte & mask & pin_direction_select)
                         | (sync2 & ~pin_direction_select & CONNECTED);
      if (wr)
      begin
        case (addr)
          `OFF_DIR: pin_direction_select <= wbyte;
          `OFF_IS: irq_sense_select <= wbyte;
          `OFF_IBE: irq_both_edge_select <= wbyte;
          `OFF_IEV: irq_polarity_select <= wbyte;
          `OFF_IM: irq_enable_mask <= wbyte;
          `OFF_AFSEL:
            // protected bits keep their value unless committed
            alt_function_select <= (alt_function_select & DEBUG_PINS & ~commit_enable_reg)
                                   | (wbyte & ~(DEBUG_PINS & ~commit_enable_reg));
          `OFF_DR2: drive_2ma_select <= wbyte | (drive_2ma_select & ~CONNECTED);
          `OFF_DR4: drive_4ma_select <= wbyte;
          `OFF_DR8: drive_8ma_select <= wbyte;
          `OFF_ODR: open_drain_select <= wbyte;
          `OFF_PUR: pull_up_select <= wbyte;
          `OFF_PDR: pull_down_select <= wbyte;
          `OFF_SLR: slew_select <= wbyte;
          `OFF_DEN: digital_enable_select <= wbyte;
          `OFF_LOCK: unlocked <= (wdata == `UNLOCK_KEY);
          `OFF_CR:
            if (unlocked)
              commit_enable_reg <= (commit_enable_reg & ~DEBUG_PINS)
                                   | (wbyte & DEBUG_PINS);
          default: ;
        endcase
      end
    end
  end

  // ==========================================================
  // read mux
  always @*
  begin
    next_rdata = 32'h00000000;
    if (data_hit)
      next_rdata = {24'h000000, pin_value_reg & mask};
    else
    begin
      case (addr)
        `OFF_DIR: next_rdata = {24'h000000, pin_direction_select};
        `OFF_IS: next_rdata = {24'h000000, irq_sense_select};
        `OFF_IBE: next_rdata = {24'h000000, irq_both_edge_select};
        `OFF_IEV: next_rdata = {24'h000000, irq_polarity_select};
        `OFF_IM: next_rdata = {24'h000000, irq_enable_mask};
        `OFF_RIS: next_rdata = {24'h000000, irq_raw_status};
        `OFF_MIS: next_rdata = {24'h000000, irq_masked_status};
        `OFF_AFSEL: next_rdata = {24'h000000, alt_function_select};
        `OFF_DR2: next_rdata = {24'h000000, drive_2ma_select};
        `OFF_DR4: next_rdata = {24'h000000, drive_4ma_select};
        `OFF_DR8: next_rdata = {24'h000000, drive_8ma_select};
        `OFF_ODR: next_rdata = {24'h000000, open_drain_select};
        `OFF_PUR: next_rdata = {24'h000000, pull_up_select};
        `OFF_PDR: next_rdata = {24'h000000, pull_down_select};
        `OFF_SLR: next_rdata = {24'h000000, slew_select};
        `OFF_DEN: next_rdata = {24'h000000, digital_enable_select};
        `OFF_LOCK: next_rdata = unlocked ? 32'h00000000 : `LOCKED_VAL;
        `OFF_CR: next_rdata = {24'h000000, commit_enable_reg};
        default:
          // identification words: 8 peripheral then 4 cell bytes
          if (addr >= `OFF_PID_BASE && addr < `OFF_CID_BASE)
            next_rdata = {24'h000000, PERIPH_ID[{addr[4:2], 3'h0} +: 8]};
          else if (addr >= `OFF_CID_BASE)
            next_rdata = {24'h000000, CELL_ID[{addr[3:2], 3'h0} +: 8]};
      endcase
    end
  end

  // ==========================================================
  // pin drive
  always @*
  begin
    // afsel hands the pad to the peripheral
    next_out = (alt_function_select & periph_out)
               | (~alt_function_select & pin_value_reg);
    next_oe_n = ~((alt_function_select & periph_oe)
                  | (~alt_function_select & pin_direction_select));
    // open drain only ever pulls low
    next_oe_n = next_oe_n | (open_drain_select & next_out);
    next_out = next_out & ~open_drain_select;
    next_oe_n = next_oe_n | ~CONNECTED | ~digital_enable_select;
  end

  // ==========================================================
  // registered outputs
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata <= 32'h00000000;
      pin_out <= 8'h00;
      pin_oe_n <= 8'hff;
      periph_in <= 8'h00;
      port_irq <= 1'b0;
    end
    else
    begin
      rdata <= rd ? next_rdata : 32'h00000000;
      pin_out <= next_out;
      pin_oe_n <= next_oe_n;
      periph_in <= sync2 & alt_function_select;
      port_irq <= |irq_masked_status;
    end
  end
endmodule // gpio_port

/* verif/gpio_port_props.sv */
// checker on the gpio port bus, pad and pin outputs
`timescale 1ns/1ns
`include "gpio_port_regs.vh"
module gpio_port_props
(
  // clock, reset and bus
  input wire clk,
  input wire rst_n,
  input wire [11:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  input wire [31:0] rdata,
  // pins and pad
  input wire [7:0] pin_oe_n,
  input wire [7:0] periph_in,
  input wire [7:0] alt_function_select,
  input wire [7:0] digital_enable_select,
  input wire [7:0] pull_up_select,
  input wire [7:0] pull_down_select,
  input wire [7:0] slew_select,
  input wire [7:0] drive_2ma_select
);
  // ==========
  // commit tracking, bit 7 is the debug pin of this instance
  reg unlocked;
  reg cr7;
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      unlocked <= 1'b0;
      cr7 <= 1'b0;
    end
    else if (wr && addr == `OFF_LOCK)
      unlocked <= (wdata == `UNLOCK_KEY);
    else if (wr && addr == `OFF_CR && unlocked)
      cr7 <= wdata[7];
  end
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_afsel_wr;
    wr && addr == `OFF_AFSEL;
  endsequence
  sequence s_data_rd;
    rd && addr[11:10] == 2'b00;
  endsequence
  a_afsel_guard: assert property (s_afsel_wr ##0 !cr7 |=> $stable(alt_function_select[7]))
    else $error("protected afsel bit changed");
  a_afsel_plain: assert property (s_afsel_wr |=> alt_function_select[6:0] == $past(wdata[6:0]))
    else $error("plain afsel bits not written");
  a_mask_read: assert property (s_data_rd |=> rdata == {24'h0, rdata[7:0] & $past(addr[9:2])})
    else $error("masked-out data bit read nonzero");
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data outside answer cycle");
  a_reset_vals: assert property (!$past(rst_n) |-> alt_function_select == 8'h80 &&
    pull_up_select == 8'h80 && pull_down_select == 8'h00 && pin_oe_n == 8'hff)
    else $error("reset defaults wrong");
  a_pad_stable: assert property (!$past(wr) |-> $stable(pull_up_select) && $stable(slew_select) &&
    $stable(pull_down_select) && $stable(drive_2ma_select))
    else $error("pad select changed without write");
  a_den_undriven: assert property ((pin_oe_n | digital_enable_select |
    $past(digital_enable_select)) == 8'hff)
    else $error("pin driven with digital enable off");
  a_periph_gate: assert property ((periph_in & ~(alt_function_select |
    $past(alt_function_select))) == 8'h00)
    else $error("peripheral input on software pin");
endmodule // gpio_port_props
bind gpio_port gpio_port_props i_props (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .pin_oe_n(pin_oe_n), .periph_in(periph_in),
  .alt_function_select(alt_function_select), .digital_enable_select(digital_enable_select),
  .pull_up_select(pull_up_select), .pull_down_select(pull_down_select),
  .slew_select(slew_select), .drive_2ma_select(drive_2ma_select));

/* verif/pin_model.sv */
// outside circuitry on the eight port pins
`timescale 1ns/1ns
module pin_model
(
  // clock and reset
  input wire clk,
  input wire rst_n,
  // port side
  input wire [7:0] pin_out,
  input wire [7:0] pin_oe_n,
  input wire [7:0] pull_up,
  input wire [7:0] pull_down,
  // outside drivers
  input wire [7:0] ext_en,
  input wire [7:0] ext_val,
  output wire [7:0] pin_in
);
  // ==========
  // a floating pin with no pull toggles, so no stale level is read
  reg flip = 1'b0;
  wire [7:0] idle;
  wire [7:0] ext;
  always @(posedge clk)
    flip <= ~flip;
  assign idle = pull_up | ({8{flip}} & ~pull_down);
  assign ext = (ext_en & ext_val) | (~ext_en & idle);
  // debug reset pin kept high while the port is reset
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext) | {~rst_n, 7'h0};
endmodule // pin_model

/* verif/gpio_port_with_masked_access_bench.sv */
// self-checking bench for one gpio port instance
`timescale 1ns/1ns
`include "gpio_port_regs.vh"
module gpio_port_with_masked_access_bench;
  // ==========
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg [11:0] addr = 12'h0;
  reg [31:0] wdata = 32'h0;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg [7:0] periph_out = 8'h0;
  reg [7:0] periph_oe = 8'h0;
  reg [7:0] ext_en = 8'h0;
  reg [7:0] ext_val = 8'h0;
  wire [31:0] rdata;
  wire [7:0] pin_in, pin_out, pin_oe_n, periph_in, afs, den, pur, pdr, dr2, dr4, dr8, odr, slr;
  wire port_irq;
  integer seed = 78729;
  integer n_mismatch = 0;
  integer checks_done = 0;
  integer i, k;
  reg [7:0] m, d, data, v0;
  reg h1, h2;
  gpio_port #(.DEBUG_PINS(8'h80)) i_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .periph_out(periph_out), .periph_oe(periph_oe), .periph_in(periph_in),
    .alt_function_select(afs), .digital_enable_select(den), .pull_up_select(pur),
    .pull_down_select(pdr), .drive_2ma_select(dr2), .drive_4ma_select(dr4),
    .drive_8ma_select(dr8), .open_drain_select(odr), .slew_select(slr), .port_irq(port_irq));
  pin_model i_pins (.clk(clk), .rst_n(rst_n), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pull_up(pur), .pull_down(pdr), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
  initial
    forever #5 clk = ~clk;
  function hit(input [2:0] c, input o, input n);
    hit = c[2] ? (n == c[0]) : ((o != n) && (c[1] || n == c[0]));
  endfunction
  task check(input [31:0] seen, input [31:0] exp);
  begin
    checks_done = checks_done + 1;
    if (seen !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  task wreg(input [11:0] a, input [31:0] dd);
  begin
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= dd;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  end
  endtask
  task rchk(input [11:0] a, input [31:0] e);
  begin
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(rdata, e);
  end
  endtask
  task settle(input integer n);
  begin
    repeat (n) @(posedge clk);
    #1;
  end
  endtask
  task results;
  begin
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask
  // watchdog well beyond the several hundred cycles of the tests
  initial
  begin
    #500000;
    n_mismatch = n_mismatch + 1;
    results;
  end
  initial
  begin
    settle(12);
    rst_n <= 1'b1;
    check({afs, den, pur, pdr}, 32'h80808000);
    check({pin_oe_n, pin_out, dr2, dr4}, 32'hff00ff00);
    settle(3);
    rchk(`OFF_CR, 32'h7f);
    rchk(`OFF_LOCK, `LOCKED_VAL);
    rchk(12'h600, 32'h0);
    rchk(`OFF_PID_BASE, 32'h0);
    rchk(`OFF_CID_BASE, 32'h0);
    $display("test reset done");
    periph_oe <= 8'h80;
    for (i = 0; i < 4; i = i + 1)
    begin
      d = $random(seed);
      @(posedge clk);
      periph_out <= d;
      settle(5);
      check({pin_out[7], pin_oe_n[7], periph_in[7]}, {d[7], 1'b0, d[7]});
    end
    $display("test alternate done");
    wreg(`OFF_DEN, 32'hff);
    wreg(`OFF_DIR, 32'h7f);
    // output bits kept what the floating inputs showed, so start them known
    wreg(`OFF_DATA_LAST, 32'h0);
    data = 8'h00;
    for (i = 0; i < 24; i = i + 1)
    begin
      m = (i == 0) ? 8'h00 : (i == 1) ? 8'h7f : $random(seed) & 8'h7f;
      d = $random(seed);
      wreg({2'b00, m, 2'b00}, {24'h0, d});
      data = (data & ~m) | (d & m);
      m = $random(seed) & 8'h7f;
      rchk({2'b00, m, 2'b00}, data & m);
      check(pin_out[6:0], data[6:0]);
    end
    $display("test data done");
    wreg(`OFF_DIR, 32'h0f);
    ext_en <= 8'h70;
    for (i = 0; i < 3; i = i + 1)
    begin
      d = $random(seed);
      @(posedge clk);
      ext_val <= d;
      wreg(`OFF_DATA_LAST, 32'hff);
      settle(4);
      rchk(12'h1c0, d & 8'h70);
      check(pin_out[3:0], 4'hf);
    end
    $display("test input done");
    for (k = 0; k < 8; k = k + 1)
    begin
      v0 = $random(seed);
      wreg(`OFF_IM, 32'h0);
      wreg(`OFF_IS, {k[2], 4'h0});
      wreg(`OFF_IBE, {k[1], 4'h0});
      wreg(`OFF_IEV, {k[0], 4'h0});
      @(posedge clk);
      ext_val <= v0;
      settle(6);
      wreg(`OFF_ICR, 32'hff);
      wreg(`OFF_IM, 32'h10);
      // pin 4 level flipped, then held until the status is read
      @(posedge clk);
      ext_val <= v0 ^ 8'h10;
      h1 = hit(k[2:0], v0[4], ~v0[4]);
      settle(6);
      check(port_irq, h1);
      rchk(`OFF_RIS, {h1, 4'h0});
      rchk(`OFF_MIS, {h1, 4'h0});
      @(posedge clk);
      ext_val <= v0;
      h2 = k[2] ? (v0[4] == k[0]) : (h1 | hit(k[2:0], ~v0[4], v0[4]));
      settle(6);
      rchk(`OFF_RIS, {h2, 4'h0});
      wreg(`OFF_ICR, 32'h0f);
      rchk(`OFF_RIS, {h2, 4'h0});
      wreg(`OFF_ICR, 32'h10);
      rchk(`OFF_RIS, {k[2] & (v0[4] == k[0]), 4'h0});
      wreg(`OFF_IM, 32'h0);
      rchk(`OFF_MIS, 32'h0);
      check(port_irq, 1'b0);
    end
    $display("test interrupt done");
    wreg(`OFF_AFSEL, 32'h7f);
    check(afs, 8'hff);
    wreg(`OFF_AFSEL, 32'h0);
    check(afs, 8'h80);
    wreg(`OFF_CR, 32'hff);
    rchk(`OFF_CR, 32'h7f);
    wreg(`OFF_LOCK, `UNLOCK_KEY);
    rchk(`OFF_LOCK, 32'h0);
    wreg(`OFF_CR, 32'hff);
    wreg(`OFF_AFSEL, 32'h0);
    rchk(`OFF_AFSEL, 32'h0);
    wreg(`OFF_LOCK, 32'h0);
    rchk(`OFF_LOCK, `LOCKED_VAL);
    $display("test commit done");
    for (i = 0; i < 7; i = i + 1)
    begin
      d = $random(seed);
      wreg(12'h500 + {i[9:0], 2'b00}, {24'h0, d});
      check(i == 0 ? dr2 : i == 1 ? dr4 : i == 2 ? dr8 : i == 3 ? odr :
        i == 4 ? pur : i == 5 ? pdr : slr, d);
      rchk(12'h500 + {i[9:0], 2'b00}, {24'h0, d});
    end
    $display("test pad done");
    @(posedge clk);
    rst_n <= 1'b0;
    settle(3);
    rst_n <= 1'b1;
    check({afs, den, pur, pdr}, 32'h80808000);
    check({pin_oe_n, pin_out, port_irq}, 17'h1fe00);
    settle(3);
    rchk(`OFF_CR, 32'h7f);
    rchk(`OFF_LOCK, `LOCKED_VAL);
    $display("test second reset done");
    results;
  end
endmodule // gpio_port_with_masked_access_bench
